/* dv/addr_map_decoder_bench.sv */
/*
 * Self-checking bench for the address map decoder.
 * Assumes grants are combinational and targets appear one edge after acceptance.
 */
`timescale 1ns/1ps
module addr_map_decoder_bench;
    import addr_map_pkg::*;
    logic CLOCK, RST_N = 1'b0, MODE_SELECT_PIN_0 = 1'b0, MODE_SELECT_PIN_1 = 1'b0;
    logic FETCH_REQ = 1'b0, FETCH_LAST_IN_LINE = 1'b0, FETCH_GRANT, MODE_VALID;
    logic [1:0] ROM_SIZE_SEL = 2'h3, RAM_SIZE_SEL = 2'h2, DATA_SIZE, DATA_HALF_BE;
    logic [31:0] FETCH_ADDR = 32'h0, BRANCH_BASE = 32'h0, BRANCH_OFFSET = 32'h0;
    logic [31:0] BRANCH_TARGET, DATA_BASE, DATA_WDATA, DATA_ADDR;
    logic DATA_REQ, DATA_WRITE, DATA_PERI_BYTE_REG, DATA_ZERO_BASE, DATA_READY, DATA_HALF_STROBE;
    logic [15:0] SIXTEEN_BIT_DISPLACEMENT, DATA_HALF_WDATA;
    logic [25:0] FETCH_PHYS;
    target_t FETCH_TARGET, DATA_TARGET;
    mode_t OP_MODE;
    logic [49:0] halves[$];
    int n_fail = 0;
    int n_compared = 0;

    addr_map_decoder i_addr_map_decoder (.CLOCK, .RST_N, .CLK_EN(1'b1), .MODE_SELECT_PIN_0, .MODE_SELECT_PIN_1,
        .ROM_SIZE_SEL, .RAM_SIZE_SEL, .FETCH_REQ, .FETCH_ADDR, .FETCH_LAST_IN_LINE, .FETCH_GRANT, .FETCH_TARGET,
        .FETCH_PHYS, .BRANCH_BASE, .BRANCH_OFFSET, .BRANCH_TARGET, .DATA_REQ, .DATA_WRITE, .DATA_SIZE,
        .DATA_PERI_BYTE_REG, .DATA_ZERO_BASE, .DATA_BASE, .SIXTEEN_BIT_DISPLACEMENT, .DATA_WDATA, .DATA_READY,
        .DATA_TARGET, .DATA_ADDR, .DATA_HALF_STROBE, .DATA_HALF_WDATA, .DATA_HALF_BE, .OP_MODE, .MODE_VALID);
    cpu_data_port_model i_cpu_data_port_model (.clock(CLOCK), .ready(DATA_READY), .req(DATA_REQ),
        .write(DATA_WRITE), .size(DATA_SIZE), .byte_reg(DATA_PERI_BYTE_REG), .zero_base(DATA_ZERO_BASE),
        .base(DATA_BASE), .disp(SIXTEEN_BIT_DISPLACEMENT), .wdata(DATA_WDATA));

    initial
    begin
        CLOCK = 1'b0;
        forever #12.5 CLOCK = ~CLOCK;
    end

    always @(posedge CLOCK)
        if (DATA_HALF_STROBE === 1'b1)
            halves.push_back({DATA_ADDR, DATA_HALF_WDATA, DATA_HALF_BE});

    task automatic chk_v(input logic [49:0] got, input logic [49:0] exp);
        n_compared++;
        if (got !== exp)
            $display("BAD %0t value %h expected %h", $time, got, exp);
        if (got !== exp)
            n_fail++;
    endtask : chk_v

    task automatic chk_t(input target_t got, input target_t exp);
        n_compared++;
        if (got !== exp)
            $display("BAD %0t target %0d expected %0d", $time, got, exp);
        if (got !== exp)
            n_fail++;
    endtask : chk_t

    task automatic close_out;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : close_out

    task automatic restart(input logic p0, input logic p1, input logic [1:0] rom, input logic [1:0] ram);
        RST_N = 1'b0;
        {MODE_SELECT_PIN_0, MODE_SELECT_PIN_1, ROM_SIZE_SEL, RAM_SIZE_SEL} = {p0, p1, rom, ram};
        repeat (12) @(posedge CLOCK);
        #1 RST_N = 1'b1;
        repeat (2) @(posedge CLOCK);
        #1;
    endtask : restart

    task automatic fetch(input logic [31:0] a, input logic last, input logic g, input target_t t);
        {FETCH_REQ, FETCH_ADDR, FETCH_LAST_IN_LINE} = {1'b1, a, last};
        #10 chk_v(FETCH_GRANT, g);
        @(posedge CLOCK);
        #1;
        chk_t(FETCH_TARGET, t);
        if (g)
            chk_v(FETCH_PHYS, a[25:0]);
    endtask : fetch

    task automatic data(input logic w, input logic [1:0] s, input logic br, input logic zb,
                        input logic [31:0] b, input logic [15:0] d, input target_t t, input logic [31:0] a);
        i_cpu_data_port_model.access(w, s, br, zb, b, d, 32'h1234abcd);
        chk_t(DATA_TARGET, t);
        chk_v(DATA_ADDR, a);
    endtask : data

    initial
    begin
        #1;
        restart(1'b1, 1'b0, 2'h3, 2'h2);
        chk_v(OP_MODE, MODE_FLASH);
        restart(1'b1, 1'b1, 2'h3, 2'h2);
        chk_v(MODE_VALID, 1'b0);
        fetch(32'h00000000, 1'b0, 1'b0, TGT_NONE);
        restart(1'b0, 1'b1, 2'h0, 2'h0);
        chk_v(OP_MODE, MODE_NORMAL);
        fetch(32'h0005fffc, 1'b0, 1'b1, TGT_ROM);
        fetch(32'h00060000, 1'b0, 1'b1, TGT_NONE);
        fetch(32'h00fffffc, 1'b0, 1'b1, TGT_EXT);
        fetch(32'h03ff6ffc, 1'b0, 1'b1, TGT_NONE);
        fetch(32'h03ff7000, 1'b0, 1'b1, TGT_RAM);
        fetch(32'h03fff000, 1'b0, 1'b0, TGT_NONE);
        fetch(32'h03ffeffc, 1'b1, 1'b0, TGT_NONE);
        fetch(32'h03ffeffc, 1'b0, 1'b1, TGT_RAM);
        data(1'b0, 2'h2, 1'b0, 1'b0, 32'h00000100, 16'h0, TGT_ROM, 32'h00000100);
        data(1'b1, 2'h2, 1'b0, 1'b0, 32'h00060100, 16'h0, TGT_EXT, 32'h00060100);
        data(1'b0, 2'h2, 1'b0, 1'b0, 32'h04000100, 16'h0, TGT_ROM, 32'h00000100);
        data(1'b0, 2'h2, 1'b0, 1'b0, 32'hfffffffc, 16'h8, TGT_ROM, 32'h00000004);
        data(1'b0, 2'h2, 1'b0, 1'b1, 32'h55555555, 16'h8000, TGT_RAM, 32'hffff8000);
        data(1'b0, 2'h2, 1'b0, 1'b0, 32'h03ff0000, 16'h0, TGT_NONE, 32'hffff0000);
        data(1'b0, 2'h2, 1'b0, 1'b0, 32'h00060100, 16'h0, TGT_NONE, 32'h00060100);
        data(1'b0, 2'h2, 1'b0, 1'b0, 32'h00200000, 16'h0, TGT_EXT, 32'h00200000);
        halves.delete();
        data(1'b1, 2'h2, 1'b0, 1'b0, 32'h03fff103, 16'h0, TGT_PERI, 32'hfffff102);
        @(posedge CLOCK);
        #1;
        chk_v(halves.size(), 2);
        chk_v(halves[0], {32'hfffff100, 16'habcd, 2'h3});
        chk_v(halves[1], {32'hfffff102, 16'h1234, 2'h3});
        data(1'b1, 2'h1, 1'b1, 1'b0, 32'h03fff010, 16'h0, TGT_PERI, 32'hfffff010);
        chk_v(DATA_HALF_BE, 2'h1);
        {BRANCH_BASE, BRANCH_OFFSET} = {32'h03fffffc, 32'h8};
        #5 chk_v(BRANCH_TARGET, 32'h4);
        {BRANCH_BASE, BRANCH_OFFSET} = {32'h0, 32'hfffffffc};
        #5 chk_v(BRANCH_TARGET, 32'h03fffffc);
        close_out();
    end

    initial
    begin
        #100000;
        n_fail++;
        close_out();
    end
endmodule : addr_map_decoder_bench

/* dv/cpu_data_port_model.sv */
/*
 * CPU core data port model: issues one load or store and holds it until accepted, for at most nine rising edges.
 * Assumes it is called 1 ns after a rising clock edge.
 */
`timescale 1ns/1ps
module cpu_data_port_model
(
    // Clock and acceptance.
    input wire logic clock,
    input wire logic ready,
    // Request towards the decoder.
    output logic req,
    output logic write,
    output logic [1:0] size,
    output logic byte_reg,
    output logic zero_base,
    output logic [31:0] base,
    output logic [15:0] disp,
    output logic [31:0] wdata
);
    initial
    begin
        req = 1'b0;
        {write, size, byte_reg, zero_base, base, disp, wdata} = '0;
    end

    task automatic access(input logic w, input logic [1:0] s, input logic br, input logic zb,
                          input logic [31:0] b, input logic [15:0] d, input logic [31:0] wd);
        int n;
        n = 0;
        // One edge with the request low separates two accesses.
        @(posedge clock);
        #1 {req, write, size, byte_reg, zero_base, base, disp, wdata} = {1'b1, w, s, br, zb, b, d, wd};
        #1;
        // Ready is looked at while it stands before the edge that takes the request.
        while (ready !== 1'b1 && n < 8)
        begin
            n++;
            @(posedge clock);
            #1;
        end
        @(posedge clock);
        // Idle base, displacement and write data lines are inverted, so a late sample of them cannot pass by luck.
        #1 req = 1'b0;
        {base, disp, wdata} = ~{base, disp, wdata};
    endtask : access
endmodule : cpu_data_port_model

/* include/addr_map_pkg.sv */
/*
 * Constants for the mode and address map decoder: region bounds, memory
 * size choices, mode codes and target codes.
 * Assumes a single 40 MHz system clock and a synchronous active-low reset.
 */
// Operation
// - Mode pin 0 low at release: normal mode
// - Pin 0 high, pin 1 low: flash programming
// - Program counter upper six bits always zero
// - Branch carry out of bit 25 dropped
// - Never fetch from peripheral register region
// - Data bits 31..26 ignored for physical space
// - Operand address sum keeps 32 bits only
// - Low 1 MB: fetch/read ROM, write external
// - ROM size variants; above fitted size prohibited
// - RAM size variants; below fitted start prohibited
// - Word peripheral access: two halfwords, low first
// - Byte register halfword access: low 8 bits
// - 00100000H..00FFFFFFH goes to external memory
// - Fetches accepted from internal RAM range
// - No prefetch crosses into peripheral region
// - Data address bit 25 sign-extended to 32
// - Zero register base reaches plus/minus 32 KB
package addr_map_pkg;
    localparam logic [25:0] ROM_BASE = 26'h0000000;
    localparam logic [25:0] ROM_LIMIT = 26'h00fffff;
    localparam logic [25:0] EXT_BASE = 26'h0100000;
    localparam logic [25:0] EXT_LIMIT = 26'h0ffffff;
    localparam logic [25:0] RAM_AREA_BASE = 26'h3ff0000;
    localparam logic [25:0] RAM_LIMIT = 26'h3ffefff;
    localparam logic [25:0] PERI_BASE = 26'h3fff000;
    localparam logic [25:0] ROM_END_384 = 26'h005ffff;
    localparam logic [25:0] ROM_END_512 = 26'h007ffff;
    localparam logic [25:0] ROM_END_768 = 26'h00bffff;
    localparam logic [25:0] ROM_END_1024 = 26'h00fffff;
    localparam logic [25:0] RAM_START_32 = 26'h3ff7000;
    localparam logic [25:0] RAM_START_40 = 26'h3ff5000;
    localparam logic [25:0] RAM_START_60 = 26'h3ff0000;
    localparam logic [25:0] FETCH_STEP = 26'h0000004;
    localparam int PC_BITS = 26;
    localparam logic [1:0] ROM_SIZE_DEFAULT = 2'h3;
    localparam logic [1:0] RAM_SIZE_DEFAULT = 2'h2;
    typedef enum logic [1:0] {MODE_NONE, MODE_NORMAL, MODE_FLASH, MODE_BAD} mode_t;
    typedef enum logic [2:0] {TGT_NONE, TGT_ROM, TGT_RAM, TGT_EXT, TGT_PERI} target_t;
endpackage : addr_map_pkg

/* rtl/addr_map_decoder.sv */
/*
 * Operating-mode capture and address decoder between the CPU core's fetch
 * and data ports and the memory targets.
 * Assumes inputs synchronous to CLOCK and one request per port per cycle.
 */
`timescale 1ns/1ps
module addr_map_decoder
(
    // Clock, reset, enable.
    input wire logic CLOCK,
    input wire logic RST_N,
    input wire logic CLK_EN,
    // Mode pins and memory size straps.
    input wire logic MODE_SELECT_PIN_0,
    input wire logic MODE_SELECT_PIN_1,
    input wire logic [1:0] ROM_SIZE_SEL,
    input wire logic [1:0] RAM_SIZE_SEL,
    // Fetch port.
    input wire logic FETCH_REQ,
    input wire logic [31:0] FETCH_ADDR,
    input wire logic FETCH_LAST_IN_LINE,
    output logic FETCH_GRANT,
    output addr_map_pkg::target_t FETCH_TARGET,
    output logic [25:0] FETCH_PHYS,
    // Branch target calculation.
    input wire logic [31:0] BRANCH_BASE,
    input wire logic [31:0] BRANCH_OFFSET,
    output logic [31:0] BRANCH_TARGET,
    // Data port.
    input wire logic DATA_REQ,
    input wire logic DATA_WRITE,
    input wire logic [1:0] DATA_SIZE,
    input wire logic DATA_PERI_BYTE_REG,
    input wire logic DATA_ZERO_BASE,
    input wire logic [31:0] DATA_BASE,
    input wire logic [15:0] SIXTEEN_BIT_DISPLACEMENT,
    input wire logic [31:0] DATA_WDATA,
    output logic DATA_READY,
    output addr_map_pkg::target_t DATA_TARGET,
    output logic [31:0] DATA_ADDR,
    output logic DATA_HALF_STROBE,
    output logic [15:0] DATA_HALF_WDATA,
    output logic [1:0] DATA_HALF_BE,
    // Mode outputs.
    output addr_map_pkg::mode_t OP_MODE,
    output logic MODE_VALID
);
    import addr_map_pkg::*;

    // ------------------------------------------------------------
    // Mode capture at reset release
    // ------------------------------------------------------------
    mode_t mode;
    logic [1:0] rom_size;
    logic [1:0] ram_size;
    mode_t next_mode;

    assign next_mode = !MODE_SELECT_PIN_0 ? MODE_NORMAL :
                       !MODE_SELECT_PIN_1 ? MODE_FLASH : MODE_BAD;

    always_ff @(posedge CLOCK)
    begin
        if (!RST_N)
        begin
            mode <= MODE_NONE;
            rom_size <= ROM_SIZE_DEFAULT;
            ram_size <= RAM_SIZE_DEFAULT;
        end
        else if (CLK_EN && mode == MODE_NONE)
        begin
            mode <= next_mode;
            rom_size <= ROM_SIZE_SEL;
            ram_size <= RAM_SIZE_SEL;
        end
    end

    assign OP_MODE = mode;
    assign MODE_VALID = (mode == MODE_NORMAL) || (mode == MODE_FLASH);

    // ------------------------------------------------------------
    // Fitted memory bounds
    // ------------------------------------------------------------
    logic [25:0] rom_end;
    logic [25:0] ram_start;

    assign rom_end = (rom_size == 2'h0) ? ROM_END_384 :
                     (rom_size == 2'h1) ? ROM_END_512 :
                     (rom_size == 2'h2) ? ROM_END_768 : ROM_END_1024;
    assign ram_start = (ram_size == 2'h0) ? RAM_START_32 :
                       (ram_size == 2'h1) ? RAM_START_40 : RAM_START_60;

    // ------------------------------------------------------------
    // Branch target and fetch decode
    // ------------------------------------------------------------
    logic [25:0] branch_sum;
    logic [25:0] pc;
    logic pc_rom;
    logic pc_ram;
    logic pc_ext;
    logic pc_peri;
    logic prefetch_cross;
    logic [25:0] next_line;

    assign branch_sum = BRANCH_BASE[25:0] + BRANCH_OFFSET[25:0];
    assign BRANCH_TARGET = {6'h00, branch_sum};

    assign pc = FETCH_ADDR[PC_BITS-1:0];
    assign pc_rom = pc <= rom_end;
    assign pc_ext = (pc >= EXT_BASE) && (pc <= EXT_LIMIT);
    assign pc_ram = (pc >= ram_start) && (pc <= RAM_LIMIT);
    assign pc_peri = pc >= PERI_BASE;
    assign next_line = pc + FETCH_STEP;
    assign prefetch_cross = FETCH_LAST_IN_LINE && pc_ram && (next_line >= PERI_BASE);

    // Fetch target and physical address are registered one cycle after the grant.
    logic fetch_ok;
    target_t fetch_tgt;

    assign fetch_ok = FETCH_REQ && MODE_VALID && !pc_peri && !prefetch_cross;
    assign fetch_tgt = pc_rom ? TGT_ROM : pc_ext ? TGT_EXT : pc_ram ? TGT_RAM : TGT_NONE;
    assign FETCH_GRANT = fetch_ok;

    always_ff @(posedge CLOCK)
    begin
        if (!RST_N)
        begin
            FETCH_TARGET <= TGT_NONE;
            FETCH_PHYS <= 26'h0000000;
        end
        else if (CLK_EN)
        begin
            FETCH_TARGET <= fetch_ok ? fetch_tgt : TGT_NONE;
            FETCH_PHYS <= pc;
        end
    end

    // ------------------------------------------------------------
    // Data address and decode
    // ------------------------------------------------------------
    logic [31:0] disp_ext;
    logic [31:0] base_val;
    logic [31:0] op_sum;
    logic [25:0] phys;
    logic [31:0] ext_addr;
    logic d_rom;
    logic d_ram;
    logic d_ext;
    logic d_peri;
    target_t data_tgt;

    assign disp_ext = {{16{SIXTEEN_BIT_DISPLACEMENT[15]}}, SIXTEEN_BIT_DISPLACEMENT};
    assign base_val = DATA_ZERO_BASE ? 32'h00000000 : DATA_BASE;
    assign op_sum = base_val + disp_ext;
    assign phys = op_sum[25:0];
    assign ext_addr = {{6{phys[25]}}, phys};
    assign d_rom = (phys <= ROM_LIMIT) && !DATA_WRITE && (phys <= rom_end);
    assign d_ext = ((phys <= ROM_LIMIT) && DATA_WRITE) ||
                   ((phys >= EXT_BASE) && (phys <= EXT_LIMIT));
    assign d_ram = (phys >= ram_start) && (phys <= RAM_LIMIT);
    assign d_peri = phys >= PERI_BASE;
    assign data_tgt = d_ext ? TGT_EXT : d_rom ? TGT_ROM : d_ram ? TGT_RAM :
                      d_peri ? TGT_PERI : TGT_NONE;

    // ------------------------------------------------------------
    // Peripheral halfword sequencing
    // ------------------------------------------------------------
    logic upper_pending;
    logic is_word_peri;
    logic issue;
    logic [15:0] next_hw;
    logic [31:0] word_addr;

    assign is_word_peri = DATA_REQ && MODE_VALID && (data_tgt == TGT_PERI) && (DATA_SIZE == 2'h2);
    assign issue = DATA_REQ && MODE_VALID;
    assign DATA_READY = issue && (!is_word_peri || upper_pending);
    assign word_addr = {ext_addr[31:2], 2'h0};
    assign next_hw = upper_pending ? DATA_WDATA[31:16] : DATA_WDATA[15:0];

    always_ff @(posedge CLOCK)
    begin
        if (!RST_N)
        begin
            upper_pending <= 1'b0;
            DATA_TARGET <= TGT_NONE;
            DATA_ADDR <= 32'h00000000;
            DATA_HALF_STROBE <= 1'b0;
            DATA_HALF_WDATA <= 16'h0000;
            DATA_HALF_BE <= 2'h0;
        end
        else if (CLK_EN)
        begin
            upper_pending <= is_word_peri && !upper_pending;
            DATA_TARGET <= issue ? data_tgt : TGT_NONE;
            DATA_ADDR <= (data_tgt == TGT_PERI && DATA_SIZE == 2'h2) ?
                         (upper_pending ? word_addr + 32'h00000002 : word_addr) : ext_addr;
            DATA_HALF_STROBE <= issue && (data_tgt == TGT_PERI);
            DATA_HALF_WDATA <= next_hw;
            DATA_HALF_BE <= DATA_PERI_BYTE_REG ? 2'h1 : 2'h3;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    a_fetch_no_peri: assert property (@(posedge CLOCK) disable iff (!RST_N)
        FETCH_GRANT |-> FETCH_ADDR[25:0] < PERI_BASE) else $error("fetch granted in peripheral area");
    a_branch_wrap: assert property (@(posedge CLOCK) disable iff (!RST_N)
        BRANCH_TARGET[31:26] == 6'h00) else $error("branch target high bits set");
    a_ram_fetch_ok: assert property (@(posedge CLOCK) disable iff (!RST_N)
        CLK_EN && FETCH_GRANT && FETCH_ADDR[25:0] >= RAM_START_32 && FETCH_ADDR[25:0] <= RAM_LIMIT
        |=> FETCH_TARGET == TGT_RAM) else $error("ram fetch not routed to ram");
    a_write_low_ext: assert property (@(posedge CLOCK) disable iff (!RST_N)
        CLK_EN && issue && DATA_WRITE && phys <= ROM_LIMIT |=> DATA_TARGET == TGT_EXT)
        else $error("low write not external");
    a_sign_extend: assert property (@(posedge CLOCK) disable iff (!RST_N)
        CLK_EN && issue && data_tgt != TGT_PERI |=> DATA_ADDR[31:26] == {6{DATA_ADDR[25]}})
        else $error("data address not sign extended");
    a_word_split: assert property (@(posedge CLOCK) disable iff (!RST_N)
        CLK_EN && is_word_peri && !upper_pending ##1 CLK_EN
        |-> upper_pending && DATA_ADDR[1:0] == 2'h0 ##1 DATA_ADDR[1:0] == 2'h2)
        else $error("word peripheral access not split");
    a_byte_lanes: assert property (@(posedge CLOCK) disable iff (!RST_N)
        CLK_EN && DATA_PERI_BYTE_REG |=> DATA_HALF_BE == 2'h1) else $error("byte register lanes wrong");
    a_mode_flash: assert property (@(posedge CLOCK) disable iff (!RST_N)
        CLK_EN && mode == MODE_NONE && MODE_SELECT_PIN_0 && !MODE_SELECT_PIN_1 |=> OP_MODE == MODE_FLASH)
        else $error("flash mode not taken");
    a_mode_normal: assert property (@(posedge CLOCK) disable iff (!RST_N)
        CLK_EN && mode == MODE_NONE && !MODE_SELECT_PIN_0 |=> OP_MODE == MODE_NORMAL)
        else $error("normal mode not taken");
    a_prohibited_none: assert property (@(posedge CLOCK) disable iff (!RST_N)
        CLK_EN && issue && !DATA_WRITE && phys > rom_end && phys <= ROM_LIMIT |=> DATA_TARGET == TGT_NONE)
        else $error("prohibited rom read decoded");

    // ------------------------------------------------------------
    // Further decode and sequencing checks
    // ------------------------------------------------------------
    a_mode_bad_held: assert property (@(posedge CLOCK) disable iff (!RST_N)
        CLK_EN && mode == MODE_NONE && MODE_SELECT_PIN_0 && MODE_SELECT_PIN_1 |=> OP_MODE == MODE_BAD && !MODE_VALID)
        else $error("prohibited pin setting not held off");

    a_mode_kept: assert property (@(posedge CLOCK) disable iff (!RST_N)
        CLK_EN && mode != MODE_NONE |=> $stable(OP_MODE))
        else $error("mode changed after capture");

    a_fetch_needs_mode: assert property (@(posedge CLOCK) disable iff (!RST_N)
        FETCH_GRANT |-> MODE_VALID)
        else $error("fetch granted without valid mode");

    a_fetch_rom: assert property (@(posedge CLOCK) disable iff (!RST_N)
        CLK_EN && FETCH_GRANT && pc <= rom_end |=> FETCH_TARGET == TGT_ROM)
        else $error("rom fetch not routed to rom");

    a_fetch_ext: assert property (@(posedge CLOCK) disable iff (!RST_N)
        CLK_EN && FETCH_GRANT && pc >= EXT_BASE && pc <= EXT_LIMIT |=> FETCH_TARGET == TGT_EXT)
        else $error("external fetch not routed outside");

    a_fetch_rom_gap: assert property (@(posedge CLOCK) disable iff (!RST_N)
        CLK_EN && FETCH_GRANT && pc > rom_end && pc < EXT_BASE |=> FETCH_TARGET == TGT_NONE)
        else $error("prohibited rom fetch decoded");

    a_fetch_ram_gap: assert property (@(posedge CLOCK) disable iff (!RST_N)
        CLK_EN && FETCH_GRANT && pc >= RAM_AREA_BASE && pc < ram_start |=> FETCH_TARGET == TGT_NONE)
        else $error("prohibited ram fetch decoded");

    a_prefetch_stop: assert property (@(posedge CLOCK) disable iff (!RST_N)
        FETCH_REQ && FETCH_LAST_IN_LINE && pc_ram && next_line >= PERI_BASE |-> !FETCH_GRANT)
        else $error("prefetch into peripheral area granted");

    a_fetch_phys: assert property (@(posedge CLOCK) disable iff (!RST_N)
        CLK_EN && FETCH_REQ |=> FETCH_PHYS == $past(pc))
        else $error("fetch physical address wrong");

    a_data_rom_read: assert property (@(posedge CLOCK) disable iff (!RST_N)
        CLK_EN && issue && !DATA_WRITE && phys <= rom_end |=> DATA_TARGET == TGT_ROM)
        else $error("rom read not routed to rom");

    a_data_ram: assert property (@(posedge CLOCK) disable iff (!RST_N)
        CLK_EN && issue && phys >= ram_start && phys <= RAM_LIMIT |=> DATA_TARGET == TGT_RAM)
        else $error("ram access not routed to ram");

    a_data_ram_gap: assert property (@(posedge CLOCK) disable iff (!RST_N)
        CLK_EN && issue && phys >= RAM_AREA_BASE && phys < ram_start |=> DATA_TARGET == TGT_NONE)
        else $error("prohibited ram access decoded");

    a_data_ext: assert property (@(posedge CLOCK) disable iff (!RST_N)
        CLK_EN && issue && phys >= EXT_BASE && phys <= EXT_LIMIT |=> DATA_TARGET == TGT_EXT)
        else $error("external access not routed outside");

    a_zero_base: assert property (@(posedge CLOCK) disable iff (!RST_N)
        CLK_EN && issue && DATA_ZERO_BASE && data_tgt != TGT_PERI |=> DATA_ADDR == $past(disp_ext))
        else $error("zero base address wrong");

    a_ready_mode: assert property (@(posedge CLOCK) disable iff (!RST_N)
        DATA_READY |-> MODE_VALID)
        else $error("data taken without valid mode");

    a_word_ready_late: assert property (@(posedge CLOCK) disable iff (!RST_N)
        is_word_peri && !upper_pending |-> !DATA_READY)
        else $error("word peripheral access taken in one step");

    a_half_strobes: assert property (@(posedge CLOCK) disable iff (!RST_N)
        CLK_EN && is_word_peri && !upper_pending |=> DATA_HALF_STROBE ##1 DATA_HALF_STROBE)
        else $error("word peripheral access missing a half");

    a_full_lanes: assert property (@(posedge CLOCK) disable iff (!RST_N)
        CLK_EN && !DATA_PERI_BYTE_REG |=> DATA_HALF_BE == 2'h3)
        else $error("halfword register lanes wrong");
    c_word_peri: cover property (@(posedge CLOCK) is_word_peri ##1 upper_pending);
    c_ram_fetch: cover property (@(posedge CLOCK) FETCH_GRANT && pc_ram);
    c_prefetch_block: cover property (@(posedge CLOCK) FETCH_REQ && prefetch_cross);
    c_zero_base: cover property (@(posedge CLOCK) issue && DATA_ZERO_BASE && d_peri);
endmodule : addr_map_decoder
